// *** logic/rml_mode_latch.sv ***
// Mode latch at reset release, instruction start flag, stop mode, APB registers.
// Assumes an APB master on pclk and a core giving one-cycle instruction starts.
//
// Register access over APB and the placing of the registers were chosen for this implementation.
`include "rml_params.svh"
`timescale 1ns/1ps
`default_nettype none
module rml_mode_latch (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic mode_a_pin_i,
  output logic mode_a_pin_o,
  output logic mode_a_pin_oe,
  input wire logic mode_b_pin_i,
  input wire logic wake_pin,
  input wire logic instr_start,
  output logic clock_run,
  output logic boot_rom_enable_bit,
  output logic special_mode_bit,
  output logic mode_a_select_bit,
  output logic internal_read_visibility_bit
);

  localparam logic [1:0] E_LAST = 2'(`RML_E_CYCLES - 1);

  rml_pkg::rml_state_s r_reg;
  rml_pkg::rml_state_s r_next;

  logic [2:0] pins_s;
  logic a_s;
  logic b_s;
  logic wake_s;
  logic run;
  logic e_tick;
  logic setup;
  logic access;
  logic hit_mode;
  logic hit_ctrl;
  logic wr_mode;
  logic wr_ctrl;
  logic stop_write;

  // Pins sampled continuously, reset or not
  rml_sync #(.W(3)) u_sync (
    .clk(pclk),
    .d({wake_pin, mode_b_pin_i, mode_a_pin_i}),
    .q(pins_s)
  );

  assign a_s = pins_s[0];
  assign b_s = pins_s[1];
  assign wake_s = pins_s[2];

  assign run = (r_reg.state == rml_pkg::RML_ST_RUN);
  assign e_tick = run && (r_reg.e_cnt == E_LAST);
  assign setup = psel && !penable;
  assign access = psel && penable;
  assign hit_mode = (paddr == `RML_OFF_MODE);
  assign hit_ctrl = (paddr == `RML_OFF_CTRL);
  assign wr_mode = access && pwrite && hit_mode;
  assign wr_ctrl = access && pwrite && hit_ctrl;
  assign stop_write = wr_ctrl && pwdata[`RML_BIT_STOP];

  always_comb begin
    r_next = r_reg;
    case (r_reg.state)
      rml_pkg::RML_ST_RESET: begin
        // First edge after release: take the pipelined levels
        r_next.boot_en = !b_s && !a_s;
        r_next.spec = !b_s;
        r_next.sel_a = a_s;
        r_next.vis = !b_s;
        r_next.state = rml_pkg::RML_ST_RUN;
      end
      rml_pkg::RML_ST_RUN: begin
        r_next.e_cnt = (r_reg.e_cnt == E_LAST) ? 2'h0 : r_reg.e_cnt + 2'h1;
        if (instr_start) begin
          r_next.flag_pend = 1'b1;
        end
        if (e_tick) begin
          // Flag covers exactly one bus cycle per instruction start
          r_next.flag_act = r_reg.flag_pend || instr_start;
          r_next.flag_pend = 1'b0;
        end
        if (stop_write) begin
          r_next.state = rml_pkg::RML_ST_STOP;
          r_next.flag_act = 1'b0;
          r_next.flag_pend = 1'b0;
        end
      end
      rml_pkg::RML_ST_STOP: begin
        // State, counter and flag frozen until the wake pin; mode writes and reads still act
        if (wake_s) begin
          r_next.state = rml_pkg::RML_ST_RUN;
        end
      end
      default: begin
        r_next.state = rml_pkg::RML_ST_RESET;
      end
    endcase
    // Only the boot and visibility bits are writable, and only in special modes
    if (wr_mode && r_reg.spec && r_reg.state != rml_pkg::RML_ST_RESET) begin
      r_next.boot_en = pwdata[`RML_BIT_BOOT];
      r_next.vis = pwdata[`RML_BIT_VIS];
    end
    if (setup) begin
      r_next.prdata = 32'h0;
      if (hit_mode) begin
        r_next.prdata[`RML_BIT_BOOT] = r_reg.boot_en;
        r_next.prdata[`RML_BIT_SPEC] = r_reg.spec;
        r_next.prdata[`RML_BIT_SEL_A] = r_reg.sel_a;
        r_next.prdata[`RML_BIT_VIS] = r_reg.vis;
      end else if (hit_ctrl) begin
        r_next.prdata[`RML_BIT_STOP] = (r_reg.state == rml_pkg::RML_ST_STOP);
        r_next.prdata[`RML_BIT_FLAG] = r_reg.flag_act;
        r_next.prdata[`RML_BIT_RUN] = run;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_reg.state <= rml_pkg::RML_ST_RESET;
      {r_reg.boot_en, r_reg.spec, r_reg.sel_a, r_reg.vis} <= `RML_RST_MODE;
      r_reg.e_cnt <= `RML_RST_ECNT;
      r_reg.flag_pend <= 1'b0;
      r_reg.flag_act <= 1'b0;
      r_reg.prdata <= 32'h0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign prdata = r_reg.prdata;
  assign pready = 1'b1;
  assign pslverr = access && !hit_mode && !hit_ctrl;

  // Open drain: only ever pulls low, released in reset
  assign mode_a_pin_o = 1'b0;
  assign mode_a_pin_oe = r_reg.flag_act;
  assign clock_run = (r_reg.state != rml_pkg::RML_ST_STOP);
  assign boot_rom_enable_bit = r_reg.boot_en;
  assign special_mode_bit = r_reg.spec;
  assign mode_a_select_bit = r_reg.sel_a;
  assign internal_read_visibility_bit = r_reg.vis;

  logic in_reset_state;
  assign in_reset_state = (r_reg.state == rml_pkg::RML_ST_RESET);

  sequence s_capture;
    in_reset_state;
  endsequence

  sequence s_start_run;
    run && instr_start && !stop_write;
  endsequence

  property p_capture;
    @(posedge pclk) disable iff (!presetn)
      s_capture |=> (mode_a_select_bit == $past(a_s)) && (special_mode_bit == !$past(b_s));
  endproperty
  a_capture: assert property (p_capture)
    else $error("mode bits differ from pins sampled at release");

  property p_decode;
    @(posedge pclk) disable iff (!presetn)
      s_capture |=> (boot_rom_enable_bit == ($past(!b_s) && $past(!a_s)))
        && (internal_read_visibility_bit == $past(!b_s));
  endproperty
  a_decode: assert property (p_decode)
    else $error("boot or visibility bit decoded wrongly");

  property p_normal;
    @(posedge pclk) disable iff (!presetn)
      (!in_reset_state && !special_mode_bit) |-> !boot_rom_enable_bit
        && !internal_read_visibility_bit;
  endproperty
  a_normal: assert property (p_normal)
    else $error("boot or visibility set in a normal mode");

  property p_hold;
    @(posedge pclk) disable iff (!presetn)
      !in_reset_state |=> $stable(special_mode_bit) && $stable(mode_a_select_bit);
  endproperty
  a_hold: assert property (p_hold)
    else $error("latched mode changed after release");

  property p_released_in_reset;
    @(posedge pclk) disable iff (!presetn)
      in_reset_state |-> !mode_a_pin_oe;
  endproperty
  a_released_in_reset: assert property (p_released_in_reset)
    else $error("mode A pin driven before release");

  property p_flag_follows;
    @(posedge pclk) disable iff (!presetn)
      s_start_run |-> ##[1:4] (mode_a_pin_oe || !clock_run);
  endproperty
  a_flag_follows: assert property (p_flag_follows)
    else $error("no start flag after instruction start");

  // A stop request cuts the flag short, so only quiet bus cycles are checked
  property p_flag_length;
    @(posedge pclk) disable iff (!presetn)
      ($rose(mode_a_pin_oe) && !stop_write) ##1 (!stop_write)[*2] |->
        ($past(mode_a_pin_oe) && mode_a_pin_oe) ##1 mode_a_pin_oe;
  endproperty
  a_flag_length: assert property (p_flag_length)
    else $error("start flag shorter than a bus cycle");

  property p_flag_one_cycle;
    @(posedge pclk) disable iff (!presetn)
      ($rose(mode_a_pin_oe) && !instr_start) ##1 (!instr_start)[*3]
        |=> !mode_a_pin_oe;
  endproperty
  a_flag_one_cycle: assert property (p_flag_one_cycle)
    else $error("start flag held past one bus cycle");

  property p_stop;
    @(posedge pclk) disable iff (!presetn)
      (r_reg.state == rml_pkg::RML_ST_STOP) && !wake_s |=> !clock_run && !mode_a_pin_oe
        && $stable(r_reg.e_cnt) && $stable(mode_a_select_bit);
  endproperty
  a_stop: assert property (p_stop)
    else $error("state moved during stop");

  property p_enter_stop;
    @(posedge pclk) disable iff (!presetn)
      (run && stop_write) |=> !clock_run ##1 (!clock_run || $past(wake_s));
  endproperty
  a_enter_stop: assert property (p_enter_stop)
    else $error("stop request not honoured");

  property p_flag_on_boundary;
    @(posedge pclk) disable iff (!presetn)
      $changed(mode_a_pin_oe) |-> $past(e_tick || stop_write);
  endproperty
  a_flag_on_boundary: assert property (p_flag_on_boundary)
    else $error("start flag moved off a bus cycle boundary");

  property p_flag_only_run;
    @(posedge pclk) disable iff (!presetn)
      mode_a_pin_oe |-> run && !mode_a_pin_o;
  endproperty
  a_flag_only_run: assert property (p_flag_only_run)
    else $error("start flag driven outside the run state");

  // Pins have no path into the bits once running; only a register write does
  property p_bits_steady;
    @(posedge pclk) disable iff (!presetn)
      (!in_reset_state && !wr_mode) |=> $stable(boot_rom_enable_bit)
        && $stable(internal_read_visibility_bit);
  endproperty
  a_bits_steady: assert property (p_bits_steady)
    else $error("boot or visibility bit moved without a write");

  property p_read_mode;
    @(posedge pclk) disable iff (!presetn)
      (setup && hit_mode) |=> prdata == {28'h0, $past(boot_rom_enable_bit),
        $past(special_mode_bit), $past(mode_a_select_bit),
        $past(internal_read_visibility_bit)};
  endproperty
  a_read_mode: assert property (p_read_mode)
    else $error("mode register read back wrongly");

  property p_wake;
    @(posedge pclk) disable iff (!presetn)
      ((r_reg.state == rml_pkg::RML_ST_STOP) && wake_s) |=> clock_run;
  endproperty
  a_wake: assert property (p_wake)
    else $error("wake pin did not restart the clocks");

  property p_special_write;
    @(posedge pclk) disable iff (!presetn)
      (wr_mode && !special_mode_bit && !in_reset_state) |=> $stable(boot_rom_enable_bit)
        && $stable(internal_read_visibility_bit);
  endproperty
  a_special_write: assert property (p_special_write)
    else $error("mode register written in a normal mode");

endmodule // rml_mode_latch
`default_nettype wire

// *** logic/rml_params.svh ***
// Constants for the reset mode latch and instruction start flag block.
// Assumes a 20 MHz pclk and an APB master on the register side.
// Function
// - Mode pins pass a clocked pipeline; levels before reset release are kept.
// - Captured levels load special mode and mode A select bits, which steer mode logic.
// - Mode A picks single chip or expanded; mode B picks normal or special.
// - Pins B,A: 10 single chip, 11 expanded, 00 bootstrap, 01 test.
// - Boot rom enable only in bootstrap (a mode register write also sets it in test mode); special and visibility in special modes.
// - After reset release, mode pin changes are ignored.
// - Out of reset, mode A pin pulls low for each instruction's first bus cycle.
// - Stop mode halts all clocks but keeps registers and RAM contents.
`ifndef RML_PARAMS_SVH
`define RML_PARAMS_SVH

`define RML_OFF_MODE 8'h00
`define RML_OFF_CTRL 8'h04

`define RML_BIT_VIS 0
`define RML_BIT_SEL_A 1
`define RML_BIT_SPEC 2
`define RML_BIT_BOOT 3

`define RML_BIT_STOP 0
`define RML_BIT_FLAG 1
`define RML_BIT_RUN 2

`define RML_RST_MODE 4'h0
`define RML_RST_ECNT 2'h0

`define RML_CLK_PERIOD_NS 50
`define RML_E_PERIOD_NS 200
`define RML_E_CYCLES (`RML_E_PERIOD_NS / `RML_CLK_PERIOD_NS)

`endif

// *** logic/rml_pkg.sv ***
// Types for the reset mode latch and instruction start flag block.
// Assumes rml_params.svh supplies the numeric constants.
package rml_pkg;

  typedef enum logic [1:0] {
    RML_ST_RESET = 2'h0,
    RML_ST_RUN = 2'h1,
    RML_ST_STOP = 2'h3
  } rml_state_e;

  typedef struct packed {
    rml_state_e state;
    logic boot_en;
    logic spec;
    logic sel_a;
    logic vis;
    logic [1:0] e_cnt;
    logic flag_pend;
    logic flag_act;
    logic [31:0] prdata;
  } rml_state_s;

endpackage

// *** logic/rml_sync.sv ***
// Two-flop synchroniser, one per bit, no reset so it samples during reset.
// Assumes inputs are asynchronous pins.
`timescale 1ns/1ps
`default_nettype none
module rml_sync #(
  parameter int W = 3
) (
  input wire logic clk,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_reg;

  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      always_ff @(posedge clk) begin
        meta_reg[i] <= d[i];
        q[i] <= meta_reg[i];
      end
    end
  endgenerate
endmodule // rml_sync
`default_nettype wire

// *** sim/rml_board.sv ***
// Board model: reset source, mode pin drivers and pull-ups.
// Assumes the device pulls mode A low through an open-drain output.
`timescale 1ns/1ps
`default_nettype none
module rml_board (
  input wire logic pclk,
  input wire logic rst_req,
  input wire logic supply_ok,
  input wire logic mode_a_lvl,
  input wire logic mode_b_lvl,
  input wire logic pin_a_oe,
  input wire logic pin_a_o,
  output logic presetn,
  output logic pin_a,
  output logic pin_b
);
  // Reset held low while supply is bad
  always_ff @(posedge pclk or posedge rst_req) begin
    if (rst_req) begin
      presetn <= 1'b0;
    end else begin
      presetn <= supply_ok;
    end
  end
  // Gate drive with series resistor in reset only, pull-up after
  assign pin_a = pin_a_oe ? pin_a_o : (!presetn ? mode_a_lvl : 1'b1);
  // Mode B low only with a legal supply
  assign pin_b = supply_ok ? mode_b_lvl : 1'b1;
endmodule // rml_board
`default_nettype wire

// *** sim/tb.sv ***
// Self-checking bench for the mode latch block.
// Assumes rml_board as the far side and a 20 MHz pclk.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic pclk, rst_req, sup, ma, mb, psel, penable, pwrite, wake, istart;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, err, presetn, pa, pb, pa_o, pa_oe, crun, rb, sm, msel, vis;
  int miscompares, num_checks, n;
  rml_mode_latch dut_u (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata,
    .prdata, .pready, .pslverr, .mode_a_pin_i(pa), .mode_a_pin_o(pa_o),
    .mode_a_pin_oe(pa_oe), .mode_b_pin_i(pb), .wake_pin(wake), .instr_start(istart),
    .clock_run(crun), .boot_rom_enable_bit(rb), .special_mode_bit(sm),
    .mode_a_select_bit(msel), .internal_read_visibility_bit(vis));
  rml_board brd_u (.pclk, .rst_req, .supply_ok(sup), .mode_a_lvl(ma), .mode_b_lvl(mb),
    .pin_a_oe(pa_oe), .pin_a_o(pa_o), .presetn, .pin_a(pa), .pin_b(pb));
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  function logic [31:0] mexp(input logic b, input logic a);
    return {28'h0, ~b & ~a, ~b, a, ~b};
  endfunction
  function logic [31:0] mbits();
    return {28'h0, rb, sm, msel, vis};
  endfunction
  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task boot(input logic b, input logic a);
    rst_req <= 1'b1;
    mb <= b;
    ma <= a;
    repeat (8) @(posedge pclk);
    chk({31'h0, pa_oe}, 32'h0);
    rst_req <= 1'b0;
    @(posedge pclk);
    // Pins flip at the release edge
    mb <= ~b;
    ma <= ~a;
    repeat (2) @(posedge pclk);
  endtask
  task wrap_up;
    $display("checks=%0d miscompares=%0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #100000;
    miscompares++;
    wrap_up();
  end
  initial begin
    rst_req = 1'b1;
    sup = 1'b1;
    ma = 1'b0;
    mb = 1'b1;
    {psel, penable, pwrite, wake, istart} = 5'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    miscompares = 0;
    num_checks = 0;
    @(posedge pclk);
    for (int i = 0; i < 4; i++) begin
      boot(i[1], i[0]);
      chk(mbits(), mexp(i[1], i[0]));
      apb(8'h00, 1'b0, 32'h0);
      chk(rd, mexp(i[1], i[0]));
      repeat (8) @(posedge pclk);
      chk(mbits(), mexp(i[1], i[0]));
    end
    apb(8'h00, 1'b1, 32'hF);
    apb(8'h00, 1'b0, 32'h0);
    chk(rd, 32'h2);
    @(posedge pclk);
    istart <= 1'b1;
    @(posedge pclk);
    istart <= 1'b0;
    n = 0;
    while (pa_oe !== 1'b1 && n < 6) begin
      @(posedge pclk);
      n++;
    end
    chk({31'h0, pa}, 32'h0);
    n = 0;
    while (pa_oe === 1'b1 && n < 20) begin
      @(posedge pclk);
      n++;
    end
    chk(32'(n), 32'h4);
    chk({31'h0, pa}, 32'h1);
    boot(1'b0, 1'b1);
    apb(8'h00, 1'b1, 32'h8);
    apb(8'h00, 1'b0, 32'h0);
    chk(rd, 32'hE);
    apb(8'h08, 1'b0, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    apb(8'h04, 1'b0, 32'h0);
    chk(rd, 32'h4);
    apb(8'h04, 1'b1, 32'h1);
    repeat (2) @(posedge pclk);
    chk({31'h0, crun}, 32'h0);
    istart <= 1'b1;
    @(posedge pclk);
    istart <= 1'b0;
    n = 0;
    repeat (6) begin
      @(posedge pclk);
      n += int'(pa_oe === 1'b1);
    end
    chk(32'(n), 32'h0);
    wake <= 1'b1;
    n = 0;
    while (crun !== 1'b1 && n < 8) begin
      @(posedge pclk);
      n++;
    end
    wake <= 1'b0;
    chk({31'h0, crun}, 32'h1);
    apb(8'h00, 1'b0, 32'h0);
    chk(rd, 32'hE);
    sup <= 1'b0;
    repeat (3) @(posedge pclk);
    chk(mbits(), 32'h0);
    wrap_up();
  end
endmodule // tb
`default_nettype wire
